// [verilog/link_pll_regs.sv]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module link_pll_regs (
   // Clock and reset
   input  wire  logic        aclk,
   input  wire  logic        aresetn,
   // AXI4-Lite write address and data
   input  wire  logic [11:0] s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output logic              s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   // AXI4-Lite read
   input  wire  logic [11:0] s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   // Sync output drivers
   output logic              sync_out0_driver_select,
   output logic              sync_out1_driver_select,
   // Lane PLL
   output logic              lane_pll_powerup,
   output logic              vco_cal_start,
   input  wire  logic        lane_pll_lock_in,
   // Link receivers
   output logic              link_page,
   output logic [1:0]        link_rx_enable,
   input  wire  logic [5:0]  link0_latency_value,
   input  wire  logic [5:0]  link1_latency_value,
   output logic [5:0]        link0_frame_clock_delay_value,
   output logic [5:0]        link1_frame_clock_delay_value,
   // Interrupt
   output logic              irq
);

   link_pll_regs_pkg::regs_state_t s_q;
   link_pll_regs_pkg::regs_state_t s_d;
   logic                           wr_do;
   logic [9:0]                     wr_idx;
   logic [9:0]                     rd_idx;
   logic                           lock_fall;
   logic                           lock_rise;
   logic                           lol_clear;

   // Handshake outputs are combinational from held state; data come from flops.
   assign s_axi_awready = !s_q.aw_have;
   assign s_axi_wready  = !s_q.w_have;
   assign s_axi_bvalid  = (s_q.wst == link_pll_regs_pkg::WR_RESP);
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = (s_q.rst == link_pll_regs_pkg::RD_IDLE);
   assign s_axi_rvalid  = (s_q.rst == link_pll_regs_pkg::RD_RESP);
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;

   // A write is carried out once both address and data are held.
   assign wr_do  = (s_q.wst == link_pll_regs_pkg::WR_IDLE) && s_q.aw_have && s_q.w_have;
   assign wr_idx = s_q.aw_addr[11:2];
   assign rd_idx = s_axi_araddr[11:2];

   // The lock input is treated as synchronous; edges are seen against the held copy.
   assign lock_fall = s_q.lock && !lane_pll_lock_in;
   assign lock_rise = !s_q.lock && lane_pll_lock_in;
   assign lol_clear = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_PLL_CTRL)
                      && s_q.w_data[link_pll_regs_pkg::BIT_LOL_CLEAR];

   // Driver and control outputs.
   assign sync_out0_driver_select       = s_q.sync0;
   assign sync_out1_driver_select       = s_q.sync1;
   assign lane_pll_powerup              = s_q.pll_ctrl[link_pll_regs_pkg::BIT_POWERUP];
   assign vco_cal_start                 = s_q.cal;
   assign link_page                     = s_q.rx_ctrl[link_pll_regs_pkg::BIT_LINK_PAGE];
   assign link0_frame_clock_delay_value = s_q.dly0;
   assign link1_frame_clock_delay_value = s_q.dly1;
   assign irq                           = |(s_q.irq_stat & s_q.irq_mask);

   // Link 1 is gated by dual-link mode so a stray enable in single-link mode is harmless.
   for (genvar i = 0; i < 2; i++) begin : g_link
      assign link_rx_enable[i] = s_q.rx_ctrl[i]
                                 && ((i == 0) || s_q.rx_ctrl[link_pll_regs_pkg::BIT_LINK_MODE]);
   end

   // Next-state logic for the bus, the registers and the event flags.
   always_comb begin
      logic       mapped;
      logic [7:0] d;
      mapped = 1'b0;
      d      = s_q.w_data;
      s_d    = s_q;
      s_d.cal  = 1'b0;
      s_d.lock = lane_pll_lock_in;
      if (s_axi_awvalid && !s_q.aw_have) begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_have) begin
         s_d.w_have  = 1'b1;
         s_d.w_data  = s_axi_wdata[7:0];
         s_d.w_lane0 = s_axi_wstrb[0];
      end
      // Only byte lane 0 carries register bits; upper lanes are ignored.
      if (wr_do) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.wst     = link_pll_regs_pkg::WR_RESP;
         mapped      = 1'b1;
         case (wr_idx)
            link_pll_regs_pkg::IDX_SYNC_OUT0: begin
               if (s_q.w_lane0) s_d.sync0 = d[0];
            end
            link_pll_regs_pkg::IDX_SYNC_OUT1: begin
               if (s_q.w_lane0) s_d.sync1 = d[0];
            end
            link_pll_regs_pkg::IDX_PLL_CTRL: begin
               if (s_q.w_lane0) begin
                  s_d.pll_ctrl = d[2:0];
                  // Calibration starts on a rising cal bit or on a fresh powerup.
                  s_d.cal = (d[link_pll_regs_pkg::BIT_CAL_START]
                             && !s_q.pll_ctrl[link_pll_regs_pkg::BIT_CAL_START])
                            || (d[link_pll_regs_pkg::BIT_POWERUP]
                             && !s_q.pll_ctrl[link_pll_regs_pkg::BIT_POWERUP]);
               end
            end
            link_pll_regs_pkg::IDX_PLL_STATE: begin
               mapped = 1'b1;
            end
            link_pll_regs_pkg::IDX_RX_CTRL: begin
               if (s_q.w_lane0) s_d.rx_ctrl = d[3:0];
            end
            link_pll_regs_pkg::IDX_LAT0, link_pll_regs_pkg::IDX_LAT1: begin
               mapped = 1'b1;
            end
            link_pll_regs_pkg::IDX_DLY0: begin
               if (s_q.w_lane0) s_d.dly0 = d[5:0];
            end
            link_pll_regs_pkg::IDX_DLY1: begin
               if (s_q.w_lane0) s_d.dly1 = d[5:0];
            end
            link_pll_regs_pkg::IDX_IRQ_STAT: begin
               if (s_q.w_lane0) s_d.irq_stat = s_q.irq_stat & ~d[1:0];
            end
            link_pll_regs_pkg::IDX_IRQ_MASK: begin
               if (s_q.w_lane0) s_d.irq_mask = d[1:0];
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
         s_d.bresp = mapped ? link_pll_regs_pkg::RESP_OKAY : link_pll_regs_pkg::RESP_SLVERR;
      end
      if (lol_clear) begin
         s_d.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKLOS] = 1'b0;
      end
      // Events are applied last so a set in the clearing cycle wins.
      if (lock_fall) begin
         s_d.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKLOS] = 1'b1;
      end
      if (lock_rise) begin
         s_d.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKGOT] = 1'b1;
      end
      case (s_q.wst)
         link_pll_regs_pkg::WR_RESP: begin
            if (s_axi_bready) s_d.wst = link_pll_regs_pkg::WR_IDLE;
         end
         default: begin
         end
      endcase
      // Read data are latched at address acceptance and held until taken.
      case (s_q.rst)
         link_pll_regs_pkg::RD_IDLE: begin
            if (s_axi_arvalid) begin
               s_d.rst   = link_pll_regs_pkg::RD_RESP;
               s_d.rdata = 32'h0000_0000;
               s_d.rresp = link_pll_regs_pkg::RESP_OKAY;
               case (rd_idx)
                  link_pll_regs_pkg::IDX_SYNC_OUT0: s_d.rdata[0]   = s_q.sync0;
                  link_pll_regs_pkg::IDX_SYNC_OUT1: s_d.rdata[0]   = s_q.sync1;
                  link_pll_regs_pkg::IDX_PLL_CTRL:  s_d.rdata[2:0] = s_q.pll_ctrl;
                  link_pll_regs_pkg::IDX_PLL_STATE: s_d.rdata[0]   = s_q.lock;
                  link_pll_regs_pkg::IDX_RX_CTRL:   s_d.rdata[3:0] = s_q.rx_ctrl;
                  link_pll_regs_pkg::IDX_LAT0:      s_d.rdata[5:0] = link0_latency_value;
                  link_pll_regs_pkg::IDX_LAT1:      s_d.rdata[5:0] = link1_latency_value;
                  link_pll_regs_pkg::IDX_DLY0:      s_d.rdata[5:0] = s_q.dly0;
                  link_pll_regs_pkg::IDX_DLY1:      s_d.rdata[5:0] = s_q.dly1;
                  link_pll_regs_pkg::IDX_IRQ_STAT:  s_d.rdata[1:0] = s_q.irq_stat;
                  link_pll_regs_pkg::IDX_IRQ_MASK:  s_d.rdata[1:0] = s_q.irq_mask;
                  default:                          s_d.rresp      = link_pll_regs_pkg::RESP_SLVERR;
               endcase
            end
         end
         link_pll_regs_pkg::RD_RESP: begin
            if (s_axi_rready) s_d.rst = link_pll_regs_pkg::RD_IDLE;
         end
         default: begin
            s_d.rst = link_pll_regs_pkg::RD_IDLE;
         end
      endcase
   end

   // State register; powerup resets to one so the SERDES comes up by default.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q          <= '0;
         s_q.pll_ctrl <= link_pll_regs_pkg::PLL_CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Checks on the block's own behaviour.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic wr_sync0;
   logic wr_pll;
   logic wr_dly0;
   assign wr_sync0 = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_SYNC_OUT0);
   assign wr_pll   = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_PLL_CTRL);
   assign wr_dly0  = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_DLY0);

   // Write strobes for the remaining registers that the checks follow.
   logic wr_sync1;
   logic wr_rx;
   logic wr_dly1;
   assign wr_sync1 = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_SYNC_OUT1);
   assign wr_rx    = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_RX_CTRL);
   assign wr_dly1  = wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_DLY1);

   chk_sync_select: assert property (
      wr_sync0 |=> (sync_out0_driver_select == $past(s_q.w_data[0])))
      else $error("sync driver select did not follow the write");

   chk_lol_clear: assert property (
      (lol_clear && !lock_fall) |=> !s_q.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKLOS])
      else $error("lock-loss flag not cleared by control write");

   chk_lol_set_wins: assert property (
      lock_fall |=> s_q.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKLOS])
      else $error("lock-loss event lost");

   chk_cal_pulse: assert property (
      (wr_pll && s_q.w_data[1] && !s_q.pll_ctrl[1]) |=> vco_cal_start ##1 !vco_cal_start)
      else $error("calibration start is not a single pulse after the write");

   chk_cal_cause: assert property (
      vco_cal_start |-> $past(wr_pll))
      else $error("calibration started without a control write");

   chk_power_off: assert property (
      (wr_pll && !s_q.w_data[link_pll_regs_pkg::BIT_POWERUP]) |=> !lane_pll_powerup)
      else $error("SERDES powered while powerup bit is zero");

   chk_power_cal: assert property (
      $rose(lane_pll_powerup) |-> vco_cal_start)
      else $error("powerup did not start calibration");

   chk_lock_read: assert property (
      (s_axi_arvalid && s_axi_arready && (rd_idx == link_pll_regs_pkg::IDX_PLL_STATE))
      |=> (s_axi_rdata == {31'h0000_0000, $past(s_q.lock)}))
      else $error("lock status readback wrong");

   chk_link1_gate: assert property (
      link_rx_enable[1] |-> s_q.rx_ctrl[link_pll_regs_pkg::BIT_LINK_MODE])
      else $error("link 1 enabled outside dual-link mode");

   chk_latency_read: assert property (
      (s_axi_arvalid && s_axi_arready && (rd_idx == link_pll_regs_pkg::IDX_LAT0))
      |=> (s_axi_rdata == {26'h000_0000, $past(link0_latency_value)}))
      else $error("link 0 latency readback wrong");

   chk_delay_write: assert property (
      wr_dly0 |=> (link0_frame_clock_delay_value == $past(s_q.w_data[5:0])))
      else $error("link 0 delay did not follow the write");

   chk_irq_level: assert property (
      (wr_do && s_q.w_lane0 && (wr_idx == link_pll_regs_pkg::IDX_IRQ_MASK)
       && |(s_q.w_data[1:0] & s_q.irq_stat)) |=> irq)
      else $error("interrupt low with unmasked status");

   chk_sync1_select: assert property (
      wr_sync1 |=> (sync_out1_driver_select == $past(s_q.w_data[0])))
      else $error("second sync driver select did not follow the write");

   chk_reset_power: assert property (
      $rose(aresetn) |-> (lane_pll_powerup && !vco_cal_start))
      else $error("lane PLL not powered or calibrating right after reset");

   chk_lock_gain: assert property (
      lock_rise |=> s_q.irq_stat[link_pll_regs_pkg::BIT_EV_LOCKGOT])
      else $error("lock-gained event lost");

   chk_mode_read: assert property (
      (s_axi_arvalid && s_axi_arready && (rd_idx == link_pll_regs_pkg::IDX_RX_CTRL))
      |=> (s_axi_rdata[link_pll_regs_pkg::BIT_LINK_MODE]
           == $past(s_q.rx_ctrl[link_pll_regs_pkg::BIT_LINK_MODE])))
      else $error("link mode readback wrong");

   chk_page_write: assert property (
      wr_rx |=> (link_page == $past(s_q.w_data[link_pll_regs_pkg::BIT_LINK_PAGE])))
      else $error("link page did not follow the write");

   chk_link0_enable: assert property (
      wr_rx |=> (link_rx_enable[0] == $past(s_q.w_data[0])))
      else $error("link 0 enable did not follow the write");

   chk_delay1_write: assert property (
      wr_dly1 |=> (link1_frame_clock_delay_value == $past(s_q.w_data[5:0])))
      else $error("link 1 delay did not follow the write");

   chk_reserved_read: assert property (
      (s_axi_arvalid && s_axi_arready && (rd_idx == link_pll_regs_pkg::IDX_SYNC_OUT0))
      |=> (s_axi_rdata[31:1] == 31'h0000_0000))
      else $error("reserved bits of a sync register read nonzero");

   cov_write_resp: cover property (wr_do ##1 s_axi_bvalid ##[1:4] !s_axi_bvalid);
   cov_lock_loss:  cover property (lock_fall ##[1:20] lol_clear);
   cov_cal_start:  cover property (vco_cal_start);
   cov_irq:        cover property ($rose(irq));
   cov_dual_link:  cover property (link_rx_enable == 2'h3);

endmodule

// [verilog/link_pll_regs_pkg.sv]
package link_pll_regs_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [9:0] IDX_SYNC_OUT0 = 10'h253;
   localparam logic [9:0] IDX_SYNC_OUT1 = 10'h254;
   localparam logic [9:0] IDX_PLL_CTRL  = 10'h280;
   localparam logic [9:0] IDX_PLL_STATE = 10'h281;
   localparam logic [9:0] IDX_RX_CTRL   = 10'h300;
   localparam logic [9:0] IDX_LAT0      = 10'h302;
   localparam logic [9:0] IDX_LAT1      = 10'h303;
   localparam logic [9:0] IDX_DLY0      = 10'h304;
   localparam logic [9:0] IDX_DLY1      = 10'h305;
   localparam logic [9:0] IDX_IRQ_STAT  = 10'h3f0;
   localparam logic [9:0] IDX_IRQ_MASK  = 10'h3f1;

   // Bit positions.
   localparam int BIT_POWERUP    = 0;
   localparam int BIT_CAL_START  = 1;
   localparam int BIT_LOL_CLEAR  = 2;
   localparam int BIT_LINK_PAGE  = 2;
   localparam int BIT_LINK_MODE  = 3;
   localparam int BIT_EV_LOCKLOS = 0;
   localparam int BIT_EV_LOCKGOT = 1;

   // Reset values and field widths.
   localparam logic [2:0] PLL_CTRL_RST = 3'h1;
   localparam int         FIELD_W      = 6;
   localparam int         ADDR_W       = 12;

   // Bus response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h0,
      WR_RESP = 2'h1
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'h0,
      RD_RESP = 2'h1
   } rd_state_t;

   // All state of the register block.
   typedef struct packed {
      wr_state_t   wst;
      rd_state_t   rst;
      logic        aw_have;
      logic [11:0] aw_addr;
      logic        w_have;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic [1:0]  bresp;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        sync0;
      logic        sync1;
      logic [2:0]  pll_ctrl;
      logic        lock;
      logic        cal;
      logic [3:0]  rx_ctrl;
      logic [5:0]  dly0;
      logic [5:0]  dly1;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
   } regs_state_t;

endpackage

// [dv/lane_pll_model.sv]
`timescale 1ns/10ps
// Far side of the block: a lane PLL that locks after a settling count, and two link receivers.
module lane_pll_model #(
   parameter int LOCK_CYC = 8
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Controls from the register block
   input  wire logic       powerup,
   input  wire logic       cal_start,
   input  wire logic [1:0] rx_en,
   // Status back to the register block
   output logic            lock,
   output logic [5:0]      lat0,
   output logic [5:0]      lat1
);
   logic [3:0] cnt_q;

   // A calibration or a power-down restarts the count, so lock always drops first.
   always_ff @(posedge aclk) begin
      if (!aresetn || !powerup || cal_start) begin
         cnt_q <= 4'h0;
         lock  <= 1'b0;
      end else if (cnt_q == 4'(LOCK_CYC)) begin
         lock <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // A receiver that is not brought up has no boundary to measure and reports zero.
   assign lat0 = rx_en[0] ? 6'h15 : 6'h00;
   assign lat1 = rx_en[1] ? 6'h2a : 6'h00;
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
// Self-checking bench for the link and lane PLL register block.
module testbench;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, link_rx_enable;
   logic [31:0] s_axi_rdata;
   logic        sync_out0_driver_select, sync_out1_driver_select, lane_pll_powerup;
   logic        vco_cal_start, lane_pll_lock_in, link_page, irq;
   logic [5:0]  link0_latency_value, link1_latency_value;
   logic [5:0]  link0_frame_clock_delay_value, link1_frame_clock_delay_value;
   int          n_fail = 0;
   int          cmp_count = 0;
   int          cal_cnt = 0;
   int          cycles = 0;

   link_pll_regs u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_out0_driver_select,
      .sync_out1_driver_select, .lane_pll_powerup, .vco_cal_start, .lane_pll_lock_in,
      .link_page, .link_rx_enable, .link0_latency_value, .link1_latency_value,
      .link0_frame_clock_delay_value, .link1_frame_clock_delay_value, .irq
   );

   lane_pll_model u_pll (
      .aclk(aclk), .aresetn(aresetn), .powerup(lane_pll_powerup), .cal_start(vco_cal_start),
      .rx_en(link_rx_enable), .lock(lane_pll_lock_in), .lat0(link0_latency_value),
      .lat1(link1_latency_value)
   );

   // Clock and a cycle ceiling well above the fewer than two hundred cycles the run needs.
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (cal_cnt >= 0 && vco_cal_start === 1'b1) cal_cnt++;
      if (cycles == 4000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write; readiness is sampled 1 ns after each edge, once settled, so the handshake edge is exact.
   task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                     input logic [1:0] er = link_pll_regs_pkg::RESP_OKAY);
      logic aw_t, w_t, b_t;
      logic [1:0] resp;
      int n;
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wstrb   <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      n = 0;
      b_t = 1'b0;
      while (!b_t && n < 40) begin
         #1;
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t  = s_axi_wvalid && s_axi_wready;
         b_t  = s_axi_bvalid === 1'b1;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         n++;
      end
      if (!b_t) begin
         n_fail++;
         $display("[FAIL] %0t no write response", $time);
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, resp}, {30'h0, er});
      @(posedge aclk);
   endtask

   // Bus read with comparison of data and response.
   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp,
                      input logic [1:0] er = link_pll_regs_pkg::RESP_OKAY);
      logic a_t, r_t;
      logic [31:0] dat;
      logic [1:0]  resp;
      int n;
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      n = 0;
      r_t = 1'b0;
      while (!r_t && n < 40) begin
         #1;
         a_t  = s_axi_arvalid && s_axi_arready;
         r_t  = s_axi_rvalid === 1'b1;
         dat  = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (a_t) s_axi_arvalid <= 1'b0;
         n++;
      end
      if (!r_t) begin
         n_fail++;
         $display("[FAIL] %0t no read response", $time);
      end
      s_axi_rready <= 1'b0;
      chk(dat, exp);
      chk({30'h0, resp}, {30'h0, er});
      @(posedge aclk);
   endtask

   // Waits for the model's lock, then lets the block's lock flop and status catch up.
   task automatic wait_lock();
      int n;
      n = 0;
      while (lane_pll_lock_in !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      if (lane_pll_lock_in !== 1'b1) begin
         n_fail++;
         $display("[FAIL] %0t lane PLL never locked", $time);
      end
      repeat (3) @(posedge aclk);
   endtask

   // Reset values; the lock state is read first, before the PLL can settle.
   task automatic t_reset();
      rdc(link_pll_regs_pkg::IDX_PLL_STATE, 32'h0);
      rdc(link_pll_regs_pkg::IDX_PLL_CTRL, 32'h1);
      rdc(link_pll_regs_pkg::IDX_SYNC_OUT0, 32'h0);
      rdc(link_pll_regs_pkg::IDX_RX_CTRL, 32'h0);
      rdc(link_pll_regs_pkg::IDX_DLY1, 32'h0);
      chk({31'h0, lane_pll_powerup}, 32'h1);
   endtask

   // Both drivers are set and then cleared, one write each, and checked as a pair.
   task automatic t_sync();
      wr(link_pll_regs_pkg::IDX_SYNC_OUT0, 8'hff);
      wr(link_pll_regs_pkg::IDX_SYNC_OUT1, 8'hff);
      chk({30'h0, sync_out1_driver_select, sync_out0_driver_select}, 32'h3);
      rdc(link_pll_regs_pkg::IDX_SYNC_OUT1, 32'h1);
      wr(link_pll_regs_pkg::IDX_SYNC_OUT0, 8'h00);
      wr(link_pll_regs_pkg::IDX_SYNC_OUT1, 8'h00);
      chk({30'h0, sync_out1_driver_select, sync_out0_driver_select}, 32'h0);
   endtask

   // Lock, calibration pulse, power-down, sticky loss of lock and its interrupt.
   task automatic t_pll();
      int c;
      wait_lock();
      rdc(link_pll_regs_pkg::IDX_PLL_STATE, 32'h1);
      wr(link_pll_regs_pkg::IDX_PLL_STATE, 8'h00);
      rdc(link_pll_regs_pkg::IDX_PLL_STATE, 32'h1);
      c = cal_cnt;
      wr(link_pll_regs_pkg::IDX_PLL_CTRL, 8'h03);
      chk(32'(cal_cnt - c), 32'h1);
      wr(link_pll_regs_pkg::IDX_PLL_CTRL, 8'h01);
      wait_lock();
      wr(link_pll_regs_pkg::IDX_PLL_CTRL, 8'h00);
      chk({31'h0, lane_pll_powerup}, 32'h0);
      rdc(link_pll_regs_pkg::IDX_PLL_STATE, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(link_pll_regs_pkg::IDX_IRQ_MASK, 8'h01);
      chk({31'h0, irq}, 32'h1);
      rdc(link_pll_regs_pkg::IDX_IRQ_STAT, 32'h3);
      c = cal_cnt;
      wr(link_pll_regs_pkg::IDX_PLL_CTRL, 8'h05);
      chk(32'(cal_cnt - c), 32'h1);
      chk({31'h0, irq}, 32'h0);
      wait_lock();
      rdc(link_pll_regs_pkg::IDX_IRQ_STAT, 32'h2);
      wr(link_pll_regs_pkg::IDX_IRQ_STAT, 8'h02);
      rdc(link_pll_regs_pkg::IDX_IRQ_STAT, 32'h0);
   endtask

   // Link 1 only comes up in dual-link mode; page and latency readback per link.
   task automatic t_link();
      wr(link_pll_regs_pkg::IDX_RX_CTRL, 8'h02);
      chk({30'h0, link_rx_enable}, 32'h0);
      wr(link_pll_regs_pkg::IDX_RX_CTRL, 8'hfd);
      chk({29'h0, link_page, link_rx_enable}, 32'h5);
      rdc(link_pll_regs_pkg::IDX_RX_CTRL, 32'hd);
      rdc(link_pll_regs_pkg::IDX_LAT0, 32'h15);
      rdc(link_pll_regs_pkg::IDX_LAT1, 32'h0);
      wr(link_pll_regs_pkg::IDX_RX_CTRL, 8'h0b);
      chk({29'h0, link_page, link_rx_enable}, 32'h3);
      rdc(link_pll_regs_pkg::IDX_LAT1, 32'h2a);
   endtask

   // Delay fields, reserved bits, and an address outside the map.
   task automatic t_delay();
      wr(link_pll_regs_pkg::IDX_DLY0, 8'hff);
      wr(link_pll_regs_pkg::IDX_DLY1, 8'h2a);
      chk({20'h0, link1_frame_clock_delay_value, link0_frame_clock_delay_value},
          32'habf);
      rdc(link_pll_regs_pkg::IDX_DLY0, 32'h3f);
      rdc(10'h255, 32'h0, link_pll_regs_pkg::RESP_SLVERR);
      wr(10'h255, 8'h5a, link_pll_regs_pkg::RESP_SLVERR);
   endtask

   // A second reset mid-run must put the controls back without a calibration pulse.
   task automatic t_rerun();
      wr(link_pll_regs_pkg::IDX_DLY0, 8'h11);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({31'h0, vco_cal_start}, 32'h0);
      rdc(link_pll_regs_pkg::IDX_DLY0, 32'h0);
      rdc(link_pll_regs_pkg::IDX_PLL_CTRL, 32'h1);
      chk({25'h0, link0_frame_clock_delay_value, lane_pll_powerup}, 32'h1);
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_sync();
      t_pll();
      t_link();
      t_delay();
      t_rerun();
      summarize();
   end
endmodule
